// file: rtl/sas_core.sv
// AHB-Lite slave executing the sleep and two subtract instructions
`timescale 1ns/10ps
module sas_core
  import sas_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic osc_run,
  output logic sleep_mode
);

  // Architectural state
  logic [7:0] acc_r;
  logic carry_r;
  logic half_carry_r;
  logic zero_r;
  logic power_down_flag_r;
  logic watchdog_expiry_flag_r;
  logic [6:0] faddr_r;
  logic [13:0] instr_r;
  logic [7:0] file_r [SAS_FILE_DEPTH];

  // Bus state
  logic wr_pend_r;
  logic rd_wait_r;
  logic [7:0] addr_r;
  logic [31:0] hrdata_nxt;

  // Execution signals
  logic take;
  logic exec_go;
  logic [13:0] word;
  sas_op_t op;
  logic [6:0] f_idx;
  logic dest_file;
  logic [7:0] alu_a;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic is_sleep;
  logic is_lit;
  logic is_file;
  logic is_sub;

  // Watchdog signals
  logic [7:0] watchdog_counter;
  logic [7:0] wdog_presc;
  logic wdog_ovf;

  // Address phase is taken only when the bus is ready
  assign take = hsel && htrans[1] && hready;

  // hsize is not decoded: only word transfers are supported
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= take && hwrite;
      if (take) begin
        addr_r <= haddr[7:0];
      end
    end
  end

  // Reads take one wait state so a write just before them has landed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      rd_wait_r <= 1'b0;
    end else begin
      rd_wait_r <= take && !hwrite;
      hreadyout <= !(take && !hwrite);
    end
  end

  // Read multiplexer; unmapped offsets read as zero
  always_comb begin
    hrdata_nxt = 32'h0000_0000;
    case (addr_r)
      SAS_OFF_INSTR: hrdata_nxt[13:0] = instr_r;
      SAS_OFF_ACC: hrdata_nxt[7:0] = acc_r;
      SAS_OFF_STATUS: begin
        hrdata_nxt[SAS_BIT_CARRY] = carry_r;
        hrdata_nxt[SAS_BIT_HALF] = half_carry_r;
        hrdata_nxt[SAS_BIT_ZERO] = zero_r;
        hrdata_nxt[SAS_BIT_EXPIRY] = watchdog_expiry_flag_r;
        hrdata_nxt[SAS_BIT_PDOWN] = power_down_flag_r;
        hrdata_nxt[SAS_BIT_SLEEP] = sleep_mode;
      end
      SAS_OFF_FADDR: hrdata_nxt[6:0] = faddr_r;
      SAS_OFF_FDATA: hrdata_nxt[7:0] = file_r[faddr_r];
      SAS_OFF_WDOG: hrdata_nxt[15:0] = {wdog_presc, watchdog_counter};
      default: hrdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_wait_r) begin
      hrdata <= hrdata_nxt;
    end
  end

  // Response is always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // A write to the instruction offset executes in that same data phase
  assign word = hwdata[13:0];
  // Running in the write data phase needs no wait state and no pipeline
  assign exec_go = wr_pend_r && (addr_r == SAS_OFF_INSTR) && !sleep_mode;
  assign op = sas_decode(word);
  assign is_sleep = exec_go && (op == SAS_OP_SLEEP);
  assign is_lit = exec_go && (op == SAS_OP_LIT);
  assign is_file = exec_go && (op == SAS_OP_FILE);
  assign is_sub = is_lit || is_file;
  assign f_idx = word[6:0];
  assign dest_file = word[7];

  // Minuend is the literal or the addressed file register
  assign alu_a = (op == SAS_OP_LIT) ? word[7:0] : file_r[f_idx];

  sas_alu u_alu (
    .minuend(alu_a),
    .subtrahend(acc_r),
    .diff(alu_res),
    .carry(alu_c),
    .half_carry(alu_dc),
    .zero(alu_z)
  );

  sas_wdt u_wdt (
    .hclk(hclk),
    .hresetn(hresetn),
    .clr(is_sleep),
    .count(watchdog_counter),
    .presc(wdog_presc),
    .ovf(wdog_ovf)
  );

  // Last executed word, for software visibility
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr_r <= 14'h0000;
    end else if (exec_go) begin
      instr_r <= word;
    end
  end

  // Accumulator: literal result always, file result when destination is 0
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= SAS_ACC_RST;
    end else if (is_lit) begin
      acc_r <= alu_res;
    end else if (is_file && !dest_file) begin
      acc_r <= alu_res;
    end else if (wr_pend_r && addr_r == SAS_OFF_ACC) begin
      acc_r <= hwdata[7:0];
    end
  end

  // File register array has no reset, like ordinary data memory
  always_ff @(posedge hclk) begin
    if (is_file && dest_file) begin
      file_r[f_idx] <= alu_res;
    end else if (wr_pend_r && addr_r == SAS_OFF_FDATA) begin
      file_r[faddr_r] <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      faddr_r <= 7'h00;
    end else if (wr_pend_r && addr_r == SAS_OFF_FADDR) begin
      faddr_r <= hwdata[6:0];
    end
  end

  // Arithmetic flags: sleep leaves them alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      carry_r <= 1'b0;
      half_carry_r <= 1'b0;
      zero_r <= 1'b0;
    end else if (is_sub) begin
      carry_r <= alu_c;
      half_carry_r <= alu_dc;
      zero_r <= alu_z;
    end else if (wr_pend_r && addr_r == SAS_OFF_STATUS) begin
      carry_r <= hwdata[SAS_BIT_CARRY];
      half_carry_r <= hwdata[SAS_BIT_HALF];
      zero_r <= hwdata[SAS_BIT_ZERO];
    end
  end

  // Power-down flag is read-only to software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_down_flag_r <= SAS_PDOWN_RST;
    end else if (is_sleep) begin
      power_down_flag_r <= 1'b0;
    end
  end

  // Sleep's set wins over a watchdog overflow in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watchdog_expiry_flag_r <= SAS_EXPIRY_RST;
    end else if (is_sleep) begin
      watchdog_expiry_flag_r <= 1'b1;
    end else if (wdog_ovf) begin
      watchdog_expiry_flag_r <= 1'b0;
    end
  end

  // Sleep stops the oscillator; overflow or software wake restarts it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_mode <= 1'b0;
      osc_run <= 1'b1;
    end else if (is_sleep) begin
      sleep_mode <= 1'b1;
      osc_run <= 1'b0;
    end else if (sleep_mode && (wdog_ovf ||
        (wr_pend_r && addr_r == SAS_OFF_STATUS && hwdata[SAS_BIT_WAKE]))) begin
      sleep_mode <= 1'b0;
      osc_run <= 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence seq_sleep_exec;
    is_sleep;
  endsequence

  sequence seq_sleep_done;
    !osc_run && sleep_mode && !power_down_flag_r;
  endsequence

  chk_sleep_stops_osc: assert property (seq_sleep_exec |=> seq_sleep_done)
    else $error("sleep did not stop the oscillator");

  chk_sleep_pd_clear: assert property (is_sleep |=> power_down_flag_r == 1'b0)
    else $error("power-down flag not cleared by sleep");

  chk_sleep_expiry_set: assert property (is_sleep |=> watchdog_expiry_flag_r)
    else $error("watchdog-expiry flag not set by sleep");

  chk_sleep_wdog_clear: assert property (is_sleep |=> watchdog_counter == 8'h00 && wdog_presc == 8'h00)
    else $error("watchdog not cleared by sleep");

  chk_lit_acc_value: assert property (is_lit |=> acc_r == 8'($past(word[7:0]) - $past(acc_r)))
    else $error("literal subtraction result wrong");

  chk_lit_acc_dest: assert property (is_lit ##1 (!exec_go && !(wr_pend_r && addr_r == SAS_OFF_ACC))
      |=> $stable(acc_r))
    else $error("accumulator changed without a write");

  chk_file_dest_acc: assert property (is_file && !dest_file
      |=> acc_r == 8'($past(file_r[f_idx]) - $past(acc_r)) && file_r[$past(f_idx)] == $past(file_r[f_idx]))
    else $error("file subtraction to accumulator wrong");

  chk_file_dest_file: assert property (is_file && dest_file
      |=> file_r[$past(f_idx)] == 8'($past(file_r[f_idx]) - $past(acc_r)) && $stable(acc_r))
    else $error("file subtraction to register wrong");

  chk_carry_borrow: assert property (is_sub |=> carry_r == ($past(alu_a) >= $past(acc_r)))
    else $error("carry is not the inverted borrow");

  chk_sleep_keeps_flags: assert property (is_sleep |=> $stable(carry_r) && $stable(half_carry_r) && $stable(zero_r))
    else $error("sleep changed arithmetic flags");

  chk_exec_one_cycle: assert property (exec_go |-> hreadyout ##1 instr_r == $past(word))
    else $error("instruction did not complete in one cycle");

  // Instruction words that must leave the core alone, and the software wake
  sequence seq_instr_refused;
    wr_pend_r && addr_r == SAS_OFF_INSTR && sleep_mode;
  endsequence

  sequence seq_word_inert;
    exec_go && op == SAS_OP_NONE;
  endsequence

  sequence seq_soft_wake;
    sleep_mode && wr_pend_r && addr_r == SAS_OFF_STATUS && hwdata[SAS_BIT_WAKE];
  endsequence

  // Subtraction flag checks, then refusal, inert-word and power-down checks
  chk_zero_result: assert property (is_sub |=> zero_r == ($past(alu_a) == $past(acc_r)))
    else $error("zero flag does not match the result");

  chk_half_borrow: assert property (is_sub
      |=> half_carry_r == ($past(alu_a[3:0]) >= $past(acc_r[3:0])))
    else $error("half-carry is not the inverted nibble borrow");

  chk_asleep_refused: assert property (seq_instr_refused |=> $stable(acc_r) && $stable(instr_r))
    else $error("instruction ran while asleep");

  chk_other_word_inert: assert property (seq_word_inert |=> $stable(acc_r) && $stable(sleep_mode))
    else $error("unknown word changed the core state");

  chk_pd_only_sleep: assert property (!is_sleep |=> $stable(power_down_flag_r))
    else $error("power-down flag changed without sleep");

  // Watchdog checks, so that the clear by sleep means something
  chk_presc_runs: assert property (!is_sleep |=> wdog_presc == 8'($past(wdog_presc) + 8'h01))
    else $error("watchdog prescaler did not advance");

  chk_wdog_tick: assert property (!is_sleep && wdog_presc == 8'hFF
      |=> watchdog_counter == 8'($past(watchdog_counter) + 8'h01))
    else $error("watchdog counter did not advance on the tick");

  // Bus and wake checks
  chk_wake_restarts: assert property (seq_soft_wake |=> !sleep_mode && osc_run)
    else $error("software wake did not restart the oscillator");

  chk_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");

  chk_resp_okay: assert property (!hresp)
    else $error("response was not OKAY");

endmodule : sas_core

// file: rtl/sas_pkg.sv
// Constants, types and decode function for the sleep and subtract execution block
package sas_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] SAS_OFF_INSTR = 8'h00;
  localparam logic [7:0] SAS_OFF_ACC = 8'h04;
  localparam logic [7:0] SAS_OFF_STATUS = 8'h08;
  localparam logic [7:0] SAS_OFF_FADDR = 8'h0C;
  localparam logic [7:0] SAS_OFF_FDATA = 8'h10;
  localparam logic [7:0] SAS_OFF_WDOG = 8'h14;

  // Status register bit positions
  localparam int SAS_BIT_CARRY = 0;
  localparam int SAS_BIT_HALF = 1;
  localparam int SAS_BIT_ZERO = 2;
  localparam int SAS_BIT_EXPIRY = 3;
  localparam int SAS_BIT_PDOWN = 4;
  localparam int SAS_BIT_SLEEP = 5;
  localparam int SAS_BIT_WAKE = 7;

  // Values after reset
  localparam logic [7:0] SAS_ACC_RST = 8'h00;
  localparam logic SAS_PDOWN_RST = 1'b1;
  localparam logic SAS_EXPIRY_RST = 1'b1;
  localparam logic [7:0] SAS_WDOG_CLR = 8'h00;
  localparam logic [7:0] SAS_PRESC_CLR = 8'h00;

  // Widths and depth
  localparam int SAS_INSTR_W = 14;
  localparam int SAS_FILE_DEPTH = 128;
  localparam int SAS_WDOG_W = 8;
  localparam int SAS_PRESC_W = 8;

  // Instruction encodings
  localparam logic [13:0] SAS_ENC_SLEEP = 14'h0063;
  localparam logic [4:0] SAS_ENC_LIT = 5'h1E;
  localparam logic [5:0] SAS_ENC_FILE = 6'h02;

  typedef enum {SAS_OP_NONE, SAS_OP_SLEEP, SAS_OP_LIT, SAS_OP_FILE} sas_op_t;

  // Classify a program word
  function automatic sas_op_t sas_decode(input logic [13:0] word);
    sas_op_t op;
    op = SAS_OP_NONE;
    if (word == SAS_ENC_SLEEP) begin
      op = SAS_OP_SLEEP;
    end else if (word[13:9] == SAS_ENC_LIT) begin
      op = SAS_OP_LIT;
    end else if (word[13:8] == SAS_ENC_FILE) begin
      op = SAS_OP_FILE;
    end
    return op;
  endfunction : sas_decode

endpackage : sas_pkg

// file: rtl/sas_alu.sv
// Eight-bit subtractor with inverted-borrow carry, half-carry and zero
`timescale 1ns/10ps
module sas_alu
  import sas_pkg::*;
(
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  output logic [7:0] diff,
  output logic carry,
  output logic half_carry,
  output logic zero
);

  logic [8:0] full;
  logic [4:0] low;

  // Add the complement plus one so the ninth bit is the inverted borrow
  always_comb begin
    full = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
    low = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
    diff = full[7:0];
    carry = full[8];
    half_carry = low[4];
    zero = (full[7:0] == 8'h00);
  end

endmodule : sas_alu

// file: rtl/sas_wdt.sv
// Watchdog prescaler and counter with synchronous clear
`timescale 1ns/10ps
module sas_wdt
  import sas_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clr,
  output logic [SAS_WDOG_W-1:0] count,
  output logic [SAS_PRESC_W-1:0] presc,
  output logic ovf
);

  logic tick;

  // Prescaler overflow is the one-cycle enable of the counter
  assign tick = (presc == {SAS_PRESC_W{1'b1}});

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc <= SAS_PRESC_CLR;
    end else if (clr) begin
      presc <= SAS_PRESC_CLR;
    end else begin
      presc <= presc + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= SAS_WDOG_CLR;
    end else if (clr) begin
      count <= SAS_WDOG_CLR;
    end else if (tick) begin
      count <= count + 8'h01;
    end
  end

  // Overflow pulse, one cycle, when the counter wraps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf <= 1'b0;
    end else begin
      ovf <= !clr && tick && (count == {SAS_WDOG_W{1'b1}});
    end
  end

endmodule : sas_wdt

// file: dv/sas_tb_top.sv
// Self-checking bench for the sleep and subtract execution block
`timescale 1ns/10ps
module sleep_and_subtract_exec_tb_top
  import sas_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, osc_run, sleep_mode;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] diff;
  int miscompares, checked;
  // Operand pairs cover borrow, half borrow, zero and both extremes
  logic [7:0] lhs [6] = '{8'h02, 8'h02, 8'h02, 8'h00, 8'h0F, 8'hFF};
  logic [7:0] rhs [6] = '{8'h01, 8'h02, 8'h03, 8'hFF, 8'h10, 8'h00};
  logic [6:0] fa [3] = '{7'h00, 7'h7F, 7'h05};

  sas_core dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .osc_run(osc_run), .sleep_mode(sleep_mode)
  );

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One single word transfer; address held until ready, data held until ready; only the hang guard ends a wait
  task bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wr ? wd : 32'h0000_0000;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    rdat = hrdata;
    check({31'h0, hresp}, 32'h0000_0000);
  endtask : bus_xfer

  task bus_wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    bus_xfer(1'b1, a, wd, dummy);
  endtask : bus_wr

  task bus_rd(input logic [7:0] a, output logic [31:0] rdat);
    bus_xfer(1'b0, a, 32'h0000_0000, rdat);
  endtask : bus_rd

  // Expected zero, half-carry and carry as status bits 2..0
  function automatic logic [31:0] flags(input logic [7:0] m, input logic [7:0] s);
    logic [7:0] d;
    d = m - s;
    return {29'h0, d == 8'h00, m[3:0] >= s[3:0], m >= s};
  endfunction : flags

  task give_verdict;
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // Hang guard at 20000 cycles, far beyond the under a thousand cycles the tests need
  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end

  initial begin
    miscompares = 0;
    checked = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset state and an unmapped offset
    bus_rd(SAS_OFF_STATUS, rd);
    check(rd, 32'h0000_0018);
    bus_rd(8'h20, rd);
    check(rd, 32'h0000_0000);
    // Literal minus accumulator, both encodings of the don't-care bit
    for (int i = 0; i < 6; i++) begin
      diff = lhs[i] - rhs[i];
      bus_wr(SAS_OFF_ACC, {24'h00_0000, rhs[i]});
      bus_wr(SAS_OFF_INSTR, {18'h0_0000, 5'h1E, i[0], lhs[i]});
      bus_rd(SAS_OFF_ACC, rd);
      check(rd, {24'h00_0000, diff});
      bus_rd(SAS_OFF_STATUS, rd);
      check(rd & 32'h0000_0007, flags(lhs[i], rhs[i]));
    end
    // File minus accumulator to either destination, edge addresses
    for (int i = 0; i < 3; i++) begin
      diff = lhs[i + 1] - rhs[i + 2];
      bus_wr(SAS_OFF_FADDR, {25'h000_0000, fa[i]});
      bus_wr(SAS_OFF_FDATA, {24'h00_0000, lhs[i + 1]});
      bus_wr(SAS_OFF_ACC, {24'h00_0000, rhs[i + 2]});
      bus_wr(SAS_OFF_INSTR, {18'h0_0000, 6'h02, i[0], fa[i]});
      bus_rd(SAS_OFF_ACC, rd);
      check(rd, {24'h00_0000, i[0] ? rhs[i + 2] : diff});
      bus_rd(SAS_OFF_FDATA, rd);
      check(rd, {24'h00_0000, i[0] ? diff : lhs[i + 1]});
      bus_rd(SAS_OFF_STATUS, rd);
      check(rd & 32'h0000_0007, flags(lhs[i + 1], rhs[i + 2]));
    end
    // Unknown word has no effect on the accumulator
    bus_wr(SAS_OFF_ACC, 32'h0000_0033);
    bus_wr(SAS_OFF_INSTR, 32'h0000_0064);
    bus_rd(SAS_OFF_ACC, rd);
    check(rd, 32'h0000_0033);
    // Let the watchdog run so that the clear is visible
    bus_wr(SAS_OFF_STATUS, 32'h0000_0005);
    repeat (600) @(posedge hclk);
    bus_rd(SAS_OFF_WDOG, rd);
    check({31'h0, rd[7:0] != 8'h00}, 32'h0000_0001);
    bus_wr(SAS_OFF_INSTR, 32'h0000_0063);
    @(negedge hclk);
    check({30'h0, sleep_mode, osc_run}, 32'h0000_0002);
    @(posedge hclk);
    bus_rd(SAS_OFF_WDOG, rd);
    check({24'h00_0000, rd[7:0]}, 32'h0000_0000);
    check({31'h0, rd[15:8] < 8'h08}, 32'h0000_0001);
    bus_rd(SAS_OFF_STATUS, rd);
    check(rd & 32'h0000_003F, 32'h0000_002D);
    check({31'h0, rd[SAS_BIT_EXPIRY]}, 32'h0000_0001);
    // Instructions are refused while asleep
    bus_wr(SAS_OFF_INSTR, 32'h0000_3C10);
    bus_rd(SAS_OFF_ACC, rd);
    check(rd, 32'h0000_0033);
    bus_rd(SAS_OFF_INSTR, rd);
    check(rd, 32'h0000_0063);
    // Wake by software and confirm the clock restarts
    bus_wr(SAS_OFF_STATUS, 32'h0000_0080);
    bus_rd(SAS_OFF_STATUS, rd);
    check({31'h0, rd[SAS_BIT_SLEEP]}, 32'h0000_0000);
    check({30'h0, sleep_mode, osc_run}, 32'h0000_0001);
    give_verdict();
  end

endmodule : sleep_and_subtract_exec_tb_top
